// ### dwsm_decoder_model.sv
// character decoder model feeding bytes and dword verdicts
`timescale 1ns/1ps
module dwsm_decoder_model (
  // clock
  input wire logic mclk,
  // decoded bytes and verdicts
  output logic char_valid,
  output logic [7:0] char_data,
  output logic char_is_k,
  output logic dword_strobe, dword_good, dword_bad, signal_lost
);
  initial {char_valid, char_data, char_is_k, dword_strobe, dword_good, dword_bad, signal_lost} = '0;
  task automatic put(input logic [7:0] d, input logic k);
    @(posedge mclk);
    #1;
    char_valid = 1'b1;
    char_data = d;
    char_is_k = k;
  endtask
  // gap idles first so a slow decoder is also seen
  task automatic send(input logic [31:0] d, input logic [3:0] k, input logic g, input int gap);
    repeat (gap) @(posedge mclk);
    for (int i = 0; i < 4; i++) put(d[8*i+:8], k[i]);
    @(posedge mclk);
    #1;
    char_valid = 1'b0;
    char_data = ~char_data;
    dword_strobe = 1'b1;
    dword_good = g;
    dword_bad = !g;
    @(posedge mclk);
    #1;
    {dword_strobe, dword_good, dword_bad} = '0;
  endtask
  task automatic lose();
    @(posedge mclk);
    #1;
    signal_lost = 1'b1;
    @(posedge mclk);
    #1;
    signal_lost = 1'b0;
  endtask
endmodule

// ### dwsm_pkg.sv
// shared constants and types for the dword synchronisation machine
package dwsm_pkg;

  // ----------------------------------------
  // character codes (decoded, with k flag)
  // ----------------------------------------
  localparam logic [7:0] DWSM_K28_5 = 8'hBC;
  localparam logic [7:0] DWSM_K28_3 = 8'h7C;

  // ----------------------------------------
  // counts and reset values
  // ----------------------------------------
  localparam logic [1:0] DWSM_LANE_RST = 2'h0;
  localparam logic [31:0] DWSM_DWORD_RST = 32'h0000_0000;
  localparam logic [3:0] DWSM_KFLAG_RST = 4'h0;
  localparam int DWSM_PRIMS_TO_SYNC = 3;
  localparam int DWSM_INVALID_TO_LOSE = 4;

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [3:0] {
    acquire_start_state,
    one_valid_state,
    two_valid_state,
    sync_acquired_state,
    lose_first_invalid_state,
    lose_first_one_valid_state,
    lose_second_invalid_state,
    lose_second_one_valid_state,
    lose_third_invalid_state,
    lose_third_one_valid_state
  } dwsm_state_t;

endpackage

// ### dwsm_sync.sv
// dword synchronisation state machine with comma alignment and primitive classifier
`timescale 1ns/1ps

module dwsm_sync
  import dwsm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // decoded characters, one per cycle, from the decoder
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic char_is_k,
  // per-dword indications from the decoder
  input wire logic dword_strobe,
  input wire logic dword_good,
  input wire logic dword_bad,
  input wire logic signal_lost,
  // event from the reset and out-of-band logic
  input wire logic out_of_band_signalling,
  // assembled dword to the connection layer
  output logic [31:0] rx_dword,
  output logic [3:0] rx_kflags,
  output logic rx_dword_valid,
  output logic rx_dword_invalid,
  output logic rx_link_primitive,
  output logic rx_sata_primitive,
  // state shown to neighbouring machines
  output logic dword_synced,
  output logic conn_sm_enable,
  output logic phy_reset_sequencer_disable,
  output logic sync_lost_pulse
);

  typedef struct packed {
    dwsm_state_t state;
    logic [1:0] lane;
    logic aligned;
    logic [31:0] asm_data;
    logic [3:0] asm_k;
    logic [31:0] dword;
    logic [3:0] kflags;
    logic dvalid;
    logic dinvalid;
    logic link_prim;
    logic sata_prim;
    logic synced;
    logic conn_en;
    logic sp_dis;
    logic lost;
  } dwsm_regs_t;

  dwsm_regs_t q_r;
  dwsm_regs_t q_nxt;

  // ----------------------------------------
  // primitive classification
  // ----------------------------------------
  // first byte is byte 0 of the assembled word, other bytes plain data
  function automatic logic [1:0] dwsm_prim_kind(input logic [31:0] d, input logic [3:0] k);
    logic [1:0] kind;
    kind = 2'h0;
    if (k == 4'h1 && d[7:0] == DWSM_K28_5)
    begin
      kind = 2'h1;
    end
    else if (k == 4'h1 && d[7:0] == DWSM_K28_3)
    begin
      kind = 2'h2;
    end
    return kind;
  endfunction

  logic [1:0] prim_kind;
  logic is_link_prim;
  logic good_now;
  logic bad_now;

  assign prim_kind = dwsm_prim_kind(q_r.dword, q_r.kflags);
  assign is_link_prim = (prim_kind == 2'h1);
  assign good_now = dword_strobe && dword_good && !dword_bad && !signal_lost;
  assign bad_now = dword_strobe && dword_bad && !signal_lost;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.dvalid = 1'b0;
    q_nxt.dinvalid = 1'b0;
    q_nxt.link_prim = 1'b0;
    q_nxt.sata_prim = 1'b0;
    q_nxt.lost = 1'b0;

    // byte assembly, lane 0 first, no reordering
    if (char_valid)
    begin
      // while hunting every comma restarts the word at lane 0
      if (char_is_k && char_data == DWSM_K28_5 &&
          (q_r.state == acquire_start_state || !q_r.aligned))
      begin
        q_nxt.asm_data = {24'h000000, char_data};
        q_nxt.asm_k = 4'h1;
        q_nxt.lane = 2'h1;
        q_nxt.aligned = 1'b1;
      end
      else if (q_r.aligned)
      begin
        q_nxt.asm_data[q_r.lane*8 +: 8] = char_data;
        q_nxt.asm_k[q_r.lane] = char_is_k;
        q_nxt.lane = q_r.lane + 2'h1;
        if (q_r.lane == 2'h3)
        begin
          q_nxt.dword = {char_data, q_r.asm_data[23:0]};
          q_nxt.kflags = {char_is_k, q_r.asm_k[2:0]};
        end
      end
    end

    // decoder verdict applies to the dword held in q_r.dword
    if (signal_lost || out_of_band_signalling)
    begin
      // direct return; lost signal while hunting just stays
      q_nxt.state = acquire_start_state;
      q_nxt.aligned = 1'b0;
      q_nxt.lane = DWSM_LANE_RST;
    end
    else if (dword_strobe)
    begin
      case (q_r.state)
        acquire_start_state:
        begin
          if (good_now && is_link_prim)
          begin
            q_nxt.state = one_valid_state;
          end
          else if (bad_now)
          begin
            q_nxt.aligned = 1'b0;  // keep hunting commas
          end
        end
        one_valid_state:
        begin
          if (good_now && is_link_prim)
          begin
            q_nxt.state = two_valid_state;
          end
          else if (bad_now)
          begin
            q_nxt.state = acquire_start_state;
            q_nxt.aligned = 1'b0;
          end
        end
        two_valid_state:
        begin
          if (good_now && is_link_prim)
          begin
            q_nxt.state = sync_acquired_state;
            q_nxt.dvalid = 1'b1;  // the third primitive is processed
            q_nxt.link_prim = 1'b1;
          end
          else if (bad_now)
          begin
            q_nxt.state = acquire_start_state;
            q_nxt.aligned = 1'b0;
          end
        end
        sync_acquired_state:
        begin
          if (bad_now)
          begin
            q_nxt.state = lose_first_invalid_state;
          end
        end
        lose_first_invalid_state:
        begin
          q_nxt.state = bad_now ? lose_second_invalid_state
                                : lose_first_one_valid_state;
        end
        lose_first_one_valid_state:
        begin
          q_nxt.state = bad_now ? lose_second_invalid_state
                                : sync_acquired_state;
        end
        lose_second_invalid_state:
        begin
          q_nxt.state = bad_now ? lose_third_invalid_state
                                : lose_second_one_valid_state;
        end
        lose_second_one_valid_state:
        begin
          q_nxt.state = bad_now ? lose_third_invalid_state
                                : lose_first_invalid_state;
        end
        lose_third_invalid_state:
        begin
          if (bad_now)
          begin
            q_nxt.state = acquire_start_state;  // fourth uncancelled error
            q_nxt.aligned = 1'b0;
            q_nxt.lost = 1'b1;
          end
          else
          begin
            q_nxt.state = lose_third_one_valid_state;
          end
        end
        lose_third_one_valid_state:
        begin
          if (bad_now)
          begin
            q_nxt.state = acquire_start_state;
            q_nxt.aligned = 1'b0;
            q_nxt.lost = 1'b1;
          end
          else
          begin
            q_nxt.state = lose_second_invalid_state;
          end
        end
        default:
        begin
          q_nxt.state = acquire_start_state;
        end
      endcase

      // forwarding only while synchronised; error states still count as synced
      if (q_r.state >= sync_acquired_state)
      begin
        q_nxt.dvalid = good_now;
        q_nxt.dinvalid = !good_now;
        q_nxt.link_prim = good_now && is_link_prim;
        q_nxt.sata_prim = good_now && prim_kind == 2'h2;
      end
      else if (!(q_r.state == two_valid_state && good_now && is_link_prim))
      begin
        q_nxt.dinvalid = 1'b1;
      end
    end

    if (q_r.synced && !signal_lost && !out_of_band_signalling && !q_nxt.lost)
    begin
      q_nxt.lost = 1'b0;
    end
    else if (q_r.synced && (signal_lost || out_of_band_signalling))
    begin
      q_nxt.lost = 1'b1;
    end

    // loss shows on the same edge as the state change since it is taken from the next state
    q_nxt.synced = q_nxt.state >= sync_acquired_state;
    q_nxt.conn_en = q_nxt.synced;
    q_nxt.sp_dis = q_nxt.state == acquire_start_state;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      q_r.state <= acquire_start_state;
      q_r.lane <= DWSM_LANE_RST;
      q_r.aligned <= 1'b0;
      q_r.asm_data <= DWSM_DWORD_RST;
      q_r.asm_k <= DWSM_KFLAG_RST;
      q_r.dword <= DWSM_DWORD_RST;
      q_r.kflags <= DWSM_KFLAG_RST;
      q_r.dvalid <= 1'b0;
      q_r.dinvalid <= 1'b0;
      q_r.link_prim <= 1'b0;
      q_r.sata_prim <= 1'b0;
      q_r.synced <= 1'b0;
      q_r.conn_en <= 1'b0;
      q_r.sp_dis <= 1'b1;
      q_r.lost <= 1'b0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // outputs, all straight from q_r
  // ----------------------------------------
  assign rx_dword = q_r.dword;
  assign rx_kflags = q_r.kflags;
  assign rx_dword_valid = q_r.dvalid;
  assign rx_dword_invalid = q_r.dinvalid;
  assign rx_link_primitive = q_r.link_prim;
  assign rx_sata_primitive = q_r.sata_prim;
  assign dword_synced = q_r.synced;
  assign conn_sm_enable = q_r.conn_en;
  assign phy_reset_sequencer_disable = q_r.sp_dis;
  assign sync_lost_pulse = q_r.lost;

endmodule

// ### dwsm_sync_assertions.sv
// concurrent checks on the ports of the dword sync machine
`timescale 1ns/1ps
module dwsm_sync_assertions
  import dwsm_pkg::*;
(
  // clock, reset and decoder side
  input wire logic mclk, rst_n, char_valid, char_is_k,
  input wire logic [7:0] char_data,
  input wire logic dword_strobe, dword_good, dword_bad, signal_lost, out_of_band_signalling,
  // machine outputs
  input wire logic [31:0] rx_dword,
  input wire logic [3:0] rx_kflags,
  input wire logic rx_dword_valid, rx_dword_invalid, rx_link_primitive, rx_sata_primitive,
  input wire logic dword_synced, conn_sm_enable, phy_reset_sequencer_disable, sync_lost_pulse
);
  // ---
  // properties
  // ---
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  reset_state_a: assert property ($rose(rst_n) |-> phy_reset_sequencer_disable)
    else $error("not in acquire start after reset");
  conn_enable_a: assert property (conn_sm_enable == dword_synced)
    else $error("connection enable differs from sync");
  seq_disable_a: assert property (phy_reset_sequencer_disable |-> !dword_synced)
    else $error("sequencer disabled while synced");
  loss_drop_a: assert property (signal_lost |=> phy_reset_sequencer_disable && !dword_synced)
    else $error("loss of signal did not restart");
  oob_entry_a: assert property (out_of_band_signalling |=> phy_reset_sequencer_disable)
    else $error("out of band event did not restart");
  unsync_block_a: assert property ((dword_strobe && !dword_synced) ##1 !dword_synced |-> !rx_dword_valid)
    else $error("dword forwarded while unsynchronised");
  bad_block_a: assert property (dword_strobe && dword_bad |=> !rx_dword_valid)
    else $error("invalid dword forwarded");
  link_code_a: assert property (rx_link_primitive |-> rx_dword_valid && rx_dword[7:0] == DWSM_K28_5)
    else $error("link primitive flag without comma byte");
  sata_code_a: assert property (rx_sata_primitive |-> rx_kflags[0] && rx_dword[7:0] == DWSM_K28_3)
    else $error("sata primitive flag without its byte");
  sync_cause_a: assert property ($rose(dword_synced) |-> $past(dword_strobe) && $past(dword_good))
    else $error("sync rose without a good dword");
  lost_cause_a: assert property (sync_lost_pulse |-> !dword_synced && $past(dword_synced))
    else $error("sync loss pulse without a drop");
  cover property (rx_link_primitive && $rose(dword_synced));
  cover property (rx_sata_primitive);
  cover property (sync_lost_pulse);
endmodule

bind dwsm_sync dwsm_sync_assertions chk (.mclk, .rst_n, .char_valid, .char_is_k, .char_data,
  .dword_strobe, .dword_good, .dword_bad, .signal_lost, .out_of_band_signalling, .rx_dword,
  .rx_kflags, .rx_dword_valid, .rx_dword_invalid, .rx_link_primitive, .rx_sata_primitive,
  .dword_synced, .conn_sm_enable, .phy_reset_sequencer_disable, .sync_lost_pulse);

// ### dwsm_sync_test.sv
// self-checking bench for the dword sync machine
`timescale 1ns/1ps
module dwsm_sync_test
  import dwsm_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, out_of_band_signalling = 1'b0;
  logic char_valid, char_is_k, dword_strobe, dword_good, dword_bad, signal_lost;
  logic [7:0] char_data;
  logic [31:0] rx_dword;
  logic [3:0] rx_kflags;
  logic rx_dword_valid, rx_dword_invalid, rx_link_primitive, rx_sata_primitive;
  logic dword_synced, conn_sm_enable, phy_reset_sequencer_disable, sync_lost_pulse;
  int miscompares = 0, cmp_count = 0, s = 0;
  // model of the alignment: bytes only land once a comma has been seen
  logic algn = 1'b0;
  int last_kind = 0;
  logic [31:0] last_d = 32'h0000_0000;
  // next state on a bad verdict, and on a good one once synced
  int bad_nx [10] = '{0, 0, 0, 4, 6, 6, 8, 8, 0, 0};
  int good_nx [10] = '{0, 1, 2, 3, 5, 3, 7, 4, 9, 6};
  always #2 mclk = ~mclk;
  dwsm_decoder_model dec (.mclk, .char_valid, .char_data, .char_is_k, .dword_strobe,
    .dword_good, .dword_bad, .signal_lost);
  dwsm_sync dut (.mclk, .rst_n, .char_valid, .char_data, .char_is_k, .dword_strobe,
    .dword_good, .dword_bad, .signal_lost, .out_of_band_signalling, .rx_dword, .rx_kflags,
    .rx_dword_valid, .rx_dword_invalid, .rx_link_primitive, .rx_sata_primitive,
    .dword_synced, .conn_sm_enable, .phy_reset_sequencer_disable, .sync_lost_pulse);
  // ---
  // expectations and compares
  // ---
  function automatic int step(int st, logic g, logic p);
    if (!g) return bad_nx[st];
    if (st < 3) return st + int'(p);
    return good_nx[st];
  endfunction
  task automatic chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t flag %b expected %b state %0d", $time, got, exp, s);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t dword %h expected %h", $time, got, exp);
    end
  endtask
  task automatic levels(input logic drop);
    chk(dword_synced, s >= 3);
    chk(conn_sm_enable, s >= 3);
    chk(phy_reset_sequencer_disable, s == 0);
    chk(sync_lost_pulse, drop);
  endtask
  // kind 0 data, 1 link primitive, 2 sata primitive
  task automatic dword(input int kind, input logic g, input int gap);
    logic [31:0] d;
    logic fwd;
    int was;
    d = $urandom;
    if (kind > 0)
      d[7:0] = kind == 1 ? DWSM_K28_5 : DWSM_K28_3;
    dec.send(d, {3'h0, kind > 0}, g, gap);
    // unaligned data bytes are dropped, so the verdict judges the old word
    if (kind > 0 || algn)
    begin
      algn = 1'b1;
      last_d = d;
      last_kind = kind;
    end
    was = s;
    s = step(s, g, last_kind == 1);
    if (!g && (was < 3 || s == 0)) algn = 1'b0;
    fwd = g && s >= 3;
    levels(was >= 3 && s < 3);
    chk(rx_dword_valid, fwd);
    chk(rx_dword_invalid, !fwd);
    chk(rx_link_primitive, fwd && last_kind == 1);
    chk(rx_sata_primitive, fwd && last_kind == 2);
    if (fwd) chk32(rx_dword, last_d);
    if (fwd) chk32({28'h0000000, rx_kflags}, {31'h00000000, last_kind > 0});
  endtask
  task automatic drop_signal(input logic by_oob);
    int was;
    was = s;
    if (by_oob)
    begin
      @(posedge mclk);
      #1;
      out_of_band_signalling = 1'b1;
      @(posedge mclk);
      #1;
      out_of_band_signalling = 1'b0;
    end
    else
      dec.lose();
    s = 0;
    algn = 1'b0;
    levels(was >= 3);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end
  initial
  begin
    int r;
    void'($urandom(17));
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    levels(1'b0);
    dec.put(8'h55, 1'b0);
    dec.put(8'h3C, 1'b0);
    for (int i = 0; i < 3; i++) dword(1, 1'b1, 0);
    repeat (4) dword(0, 1'b0, 0);
    for (int i = 0; i < 3; i++) dword(1, 1'b1, 1);
    drop_signal(1'b0);
    for (int i = 0; i < 3; i++) dword(1, 1'b1, 0);
    drop_signal(1'b1);
    for (int n = 0; n < 600; n++)
    begin
      r = $urandom_range(99);
      if (s == 0 && r > 90) dec.put(8'h4A, 1'b0);
      if (r < 3) drop_signal(r[0]);
      else dword(s >= 3 ? int'($urandom_range(2)) : int'(r < 55), r % 5 != 0, r % 3);
    end
    conclude();
  end
endmodule
